// File: design/lpdct_pkg.sv
package lpdct_pkg;

	// ************************************************************
	// Clock and cycle conversion
	// ************************************************************
	localparam real CLK_NS = 40.0;

	// A least time rounds up to whole cycles and never below one.
	function automatic int ns2cyc(input real t_ns);
		int c;
		c = $rtoi(t_ns / CLK_NS);
		if (real'(c) * CLK_NS < t_ns) begin
			c = c + 1;
		end
		if (c < 1) begin
			c = 1;
		end
		return c;
	endfunction : ns2cyc

	typedef logic [3:0] lpdct_cnt_t;
	typedef logic [7:0] lpdct_refi_t;

	// ************************************************************
	// Times in their own units
	// ************************************************************
	localparam real T_REFI_US = 7.8125;
	localparam real T_RFC_NS = 110.0;
	localparam real T_WR_NS = 15.0;
	localparam real T_XSR_NS = 112.5;
	localparam real T_RRD_NS [4] = '{10.0, 10.8, 12.0, 15.0};
	localparam real T_RP_NS [4] = '{15.0, 16.2, 18.0, 22.5};
	localparam real T_RCD_NS [4] = '{15.0, 16.2, 18.0, 22.5};
	localparam real T_RAS_NS [4] = '{40.0, 42.0, 42.0, 45.0};

	// ************************************************************
	// Cycle counts
	// ************************************************************
	// A longest interval rounds down.
	localparam lpdct_refi_t REFI_CYC =
		lpdct_refi_t'($rtoi(T_REFI_US * 1000.0 / CLK_NS));
	localparam lpdct_cnt_t RFC_CYC = lpdct_cnt_t'(ns2cyc(T_RFC_NS));
	localparam lpdct_cnt_t WR_CYC = lpdct_cnt_t'(ns2cyc(T_WR_NS));
	localparam lpdct_cnt_t XSR_CYC = lpdct_cnt_t'(ns2cyc(T_XSR_NS));
	localparam lpdct_cnt_t MRD_CYC = 4'h2;
	localparam lpdct_cnt_t STAT_CYC = 4'h2;
	localparam lpdct_cnt_t WRR_CYC [4] = '{4'h2, 4'h2, 4'h1, 4'h1};
	localparam lpdct_cnt_t XP_CYC [4] = '{4'h2, 4'h2, 4'h1, 4'h1};
	localparam lpdct_cnt_t RRD_CYC [4] = '{
		lpdct_cnt_t'(ns2cyc(T_RRD_NS[0])), lpdct_cnt_t'(ns2cyc(T_RRD_NS[1])),
		lpdct_cnt_t'(ns2cyc(T_RRD_NS[2])), lpdct_cnt_t'(ns2cyc(T_RRD_NS[3]))};
	localparam lpdct_cnt_t RP_CYC [4] = '{
		lpdct_cnt_t'(ns2cyc(T_RP_NS[0])), lpdct_cnt_t'(ns2cyc(T_RP_NS[1])),
		lpdct_cnt_t'(ns2cyc(T_RP_NS[2])), lpdct_cnt_t'(ns2cyc(T_RP_NS[3]))};
	localparam lpdct_cnt_t RCD_CYC [4] = '{
		lpdct_cnt_t'(ns2cyc(T_RCD_NS[0])), lpdct_cnt_t'(ns2cyc(T_RCD_NS[1])),
		lpdct_cnt_t'(ns2cyc(T_RCD_NS[2])), lpdct_cnt_t'(ns2cyc(T_RCD_NS[3]))};
	localparam lpdct_cnt_t RAS_CYC [4] = '{
		lpdct_cnt_t'(ns2cyc(T_RAS_NS[0])), lpdct_cnt_t'(ns2cyc(T_RAS_NS[1])),
		lpdct_cnt_t'(ns2cyc(T_RAS_NS[2])), lpdct_cnt_t'(ns2cyc(T_RAS_NS[3]))};

	// ************************************************************
	// Commands and pin codes
	// ************************************************************
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_RD = 4'h2, CMD_WR = 4'h3,
		CMD_RDA = 4'h4, CMD_WRA = 4'h5, CMD_PRE = 4'h6, CMD_REF = 4'h7,
		CMD_MRS = 4'h8, CMD_STAT = 4'h9, CMD_PDE = 4'ha, CMD_PDX = 4'hb,
		CMD_SRE = 4'hc, CMD_SRX = 4'hd
	} lpdct_cmd_e;

	typedef enum logic [1:0] {
		PS_ACT = 2'h0, PS_PDN = 2'h1, PS_SREF = 2'h2
	} lpdct_pstate_e;

	// Order is ras_n, cas_n, we_n.
	localparam logic [2:0] PIN_NOP = 3'h7;
	localparam logic [2:0] PIN_ACT = 3'h3;
	localparam logic [2:0] PIN_RD = 3'h5;
	localparam logic [2:0] PIN_WR = 3'h4;
	localparam logic [2:0] PIN_PRE = 3'h2;
	localparam logic [2:0] PIN_REF = 3'h1;
	localparam logic [2:0] PIN_MRS = 3'h0;
	localparam int AP_BIT = 10;
	localparam logic [1:0] STAT_BA = 2'h1;
	localparam int SYNC_LAT = 3;

endpackage : lpdct_pkg

// File: design/lpdct_ctrl.sv
module lpdct_ctrl (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Configuration
	input wire logic [1:0] grade_i,
	input wire logic cl3_i,
	// Command request
	input wire logic cmd_valid_i,
	input wire logic [3:0] cmd_i,
	input wire logic [1:0] bank_i,
	input wire logic [13:0] addr_i,
	input wire logic [31:0] wr_data_i,
	output logic cmd_ready_o,
	// Read return and status
	output logic rd_valid_o,
	output logic [31:0] rd_data_o,
	output logic refresh_due_o,
	output logic freq_chg_ok_o,
	// Memory pins
	output logic mem_clk_en_o,
	output logic cke_o,
	output logic cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic [1:0] ba_o,
	output logic [13:0] addr_o,
	output logic [31:0] dq_o,
	output logic [3:0] dq_oe_o,
	input wire logic [31:0] dq_i,
	output logic [3:0] dqs_o,
	output logic [3:0] dqs_oe_o
);

	// ************************************************************
	// Decode
	// ************************************************************
	lpdct_pkg::lpdct_pstate_e pstate;
	lpdct_pkg::lpdct_cnt_t glob_cnt, rrd_cnt, wrr_cnt, stat_cnt;
	lpdct_pkg::lpdct_cnt_t rcd_cnt [4];
	lpdct_pkg::lpdct_cnt_t ras_cnt [4];
	lpdct_pkg::lpdct_cnt_t rp_cnt [4];
	lpdct_pkg::lpdct_cnt_t wr_cnt [4];
	lpdct_pkg::lpdct_refi_t refi_cnt;
	logic [3:0] bank_open;
	logic [3:0] rp_busy;
	logic stat_pend;
	logic [7:0] rd_pipe;
	logic [31:0] dq_s1, dq_s2, dq_s3, dq_filt;
	logic [1:0] wr_ph;
	logic [31:0] wr_hold;

	wire c_act = cmd_i == lpdct_pkg::CMD_ACT;
	wire c_rda = cmd_i == lpdct_pkg::CMD_RDA;
	wire c_wra = cmd_i == lpdct_pkg::CMD_WRA;
	wire c_rd = c_rda || cmd_i == lpdct_pkg::CMD_RD;
	wire c_wr = c_wra || cmd_i == lpdct_pkg::CMD_WR;
	wire c_pre = cmd_i == lpdct_pkg::CMD_PRE;
	wire c_ref = cmd_i == lpdct_pkg::CMD_REF;
	wire c_mrs = cmd_i == lpdct_pkg::CMD_MRS;
	wire c_stat = cmd_i == lpdct_pkg::CMD_STAT;
	wire c_pde = cmd_i == lpdct_pkg::CMD_PDE;
	wire c_pdx = cmd_i == lpdct_pkg::CMD_PDX;
	wire c_sre = cmd_i == lpdct_pkg::CMD_SRE;
	wire c_srx = cmd_i == lpdct_pkg::CMD_SRX;

	wire in_act = pstate == lpdct_pkg::PS_ACT;
	wire all_idle = bank_open == 4'h0 && rp_busy == 4'h0;
	wire b_open = bank_open[bank_i];
	wire [3:0] lat = cl3_i ? 4'h3 : 4'h2;
	wire lpdct_pkg::lpdct_cnt_t dal_cyc =
		lpdct_pkg::WR_CYC + lpdct_pkg::RP_CYC[grade_i];
	// A status read needs no open row, only the select-to-read and write-to-read spacing.
	wire rd_ok = wrr_cnt == 4'h0 && (stat_pend ? stat_cnt == 4'h0 :
		b_open && rcd_cnt[bank_i] == 4'h0);
	// The internal precharge of a read starts one cycle on, of a write
	// after write recovery, so tRAS need only expire by then.
	wire rda_ok = ras_cnt[bank_i] <= 4'h1;
	wire wra_ok = ras_cnt[bank_i] <= lpdct_pkg::WR_CYC;

	// ************************************************************
	// Legality
	// ************************************************************
	logic legal;
	always_comb begin
		legal = 1'b0;
		if (!in_act) begin
			legal = (c_pdx && pstate == lpdct_pkg::PS_PDN) ||
				(c_srx && pstate == lpdct_pkg::PS_SREF);
		end else if (glob_cnt == 4'h0) begin
			unique case (1'b1)
				c_act: legal = !b_open && rp_cnt[bank_i] == 4'h0 &&
					rrd_cnt == 4'h0 && !refresh_due_o;
				c_rd: legal = rd_ok && (!c_rda || rda_ok) && !refresh_due_o;
				c_wr: legal = rd_ok && !stat_pend && (!c_wra || wra_ok) &&
					!refresh_due_o;
				c_pre: legal = ras_cnt[bank_i] == 4'h0 &&
					wr_cnt[bank_i] == 4'h0;
				c_ref, c_sre: legal = all_idle;
				c_mrs, c_stat: legal = all_idle && !refresh_due_o;
				c_pde: legal = !refresh_due_o;
				default: legal = cmd_i == lpdct_pkg::CMD_NOP;
			endcase
		end
	end

	assign cmd_ready_o = legal;
	wire issue = cmd_valid_i && legal;
	wire iss_rd = issue && c_rd;
	wire iss_wr = issue && c_wr;

	// ************************************************************
	// Global spacing
	// ************************************************************
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			glob_cnt <= 4'h0;
			rrd_cnt <= 4'h0;
			wrr_cnt <= 4'h0;
			stat_cnt <= 4'h0;
			stat_pend <= 1'b0;
			pstate <= lpdct_pkg::PS_ACT;
		end else begin
			if (issue && c_ref) begin
				glob_cnt <= lpdct_pkg::RFC_CYC - 4'h1;
			end else if (issue && (c_mrs || c_stat)) begin
				glob_cnt <= lpdct_pkg::MRD_CYC - 4'h1;
			end else if (iss_rd && stat_pend) begin
				glob_cnt <= lat;
			end else if (issue && c_pdx) begin
				glob_cnt <= lpdct_pkg::XP_CYC[grade_i] - 4'h1;
			end else if (issue && c_srx) begin
				glob_cnt <= lpdct_pkg::XSR_CYC - 4'h1;
			end else if (glob_cnt != 4'h0) begin
				glob_cnt <= glob_cnt - 4'h1;
			end
			if (issue && c_act) begin
				rrd_cnt <= lpdct_pkg::RRD_CYC[grade_i] - 4'h1;
			end else if (rrd_cnt != 4'h0) begin
				rrd_cnt <= rrd_cnt - 4'h1;
			end
			if (iss_wr) begin
				wrr_cnt <= lpdct_pkg::WRR_CYC[grade_i];
			end else if (wrr_cnt != 4'h0) begin
				wrr_cnt <= wrr_cnt - 4'h1;
			end
			if (issue && c_stat) begin
				stat_cnt <= lpdct_pkg::STAT_CYC - 4'h1;
				stat_pend <= 1'b1;
			end else begin
				if (stat_cnt != 4'h0) begin
					stat_cnt <= stat_cnt - 4'h1;
				end
				if (iss_rd) begin
					stat_pend <= 1'b0;
				end
			end
			if (issue && c_pde) begin
				pstate <= lpdct_pkg::PS_PDN;
			end else if (issue && c_sre) begin
				pstate <= lpdct_pkg::PS_SREF;
			end else if (issue && (c_pdx || c_srx)) begin
				pstate <= lpdct_pkg::PS_ACT;
			end
		end
	end

	// ************************************************************
	// Per-bank scoreboard
	// ************************************************************
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_bank
			wire sel = issue && bank_i == 2'(b);
			assign rp_busy[b] = rp_cnt[b] != 4'h0;
			always_ff @(posedge ref_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					bank_open[b] <= 1'b0;
					rcd_cnt[b] <= 4'h0;
					ras_cnt[b] <= 4'h0;
					rp_cnt[b] <= 4'h0;
					wr_cnt[b] <= 4'h0;
				end else begin
					if (sel && c_act) begin
						bank_open[b] <= 1'b1;
						rcd_cnt[b] <= lpdct_pkg::RCD_CYC[grade_i] - 4'h1;
						ras_cnt[b] <= lpdct_pkg::RAS_CYC[grade_i] - 4'h1;
					end else begin
						rcd_cnt[b] <= rcd_cnt[b] - 4'(rcd_cnt[b] != 4'h0);
						ras_cnt[b] <= ras_cnt[b] - 4'(ras_cnt[b] != 4'h0);
					end
					if (sel && (c_pre || c_rda || c_wra)) begin
						bank_open[b] <= 1'b0;
					end
					if (sel && c_pre) begin
						rp_cnt[b] <= lpdct_pkg::RP_CYC[grade_i] - 4'h1;
					end else if (sel && c_rda) begin
						rp_cnt[b] <= lpdct_pkg::RP_CYC[grade_i];
					end else if (sel && c_wra) begin
						rp_cnt[b] <= dal_cyc;
					end else if (rp_cnt[b] != 4'h0) begin
						rp_cnt[b] <= rp_cnt[b] - 4'h1;
					end
					// The data beat takes one cycle, recovery counts after it.
					if (sel && c_wr) begin
						wr_cnt[b] <= lpdct_pkg::WR_CYC;
					end else if (wr_cnt[b] != 4'h0) begin
						wr_cnt[b] <= wr_cnt[b] - 4'h1;
					end
				end
			end
		end
	endgenerate

	// ************************************************************
	// Refresh interval
	// ************************************************************
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			refi_cnt <= 8'h00;
		end else if ((issue && (c_ref || c_srx)) ||
			pstate == lpdct_pkg::PS_SREF) begin
			refi_cnt <= 8'h00;
		end else if (refi_cnt != lpdct_pkg::REFI_CYC) begin
			refi_cnt <= refi_cnt + 8'h01;
		end
	end
	assign refresh_due_o = refi_cnt == lpdct_pkg::REFI_CYC;
	assign freq_chg_ok_o = !in_act || !mem_clk_en_o;

	// ************************************************************
	// Command pins
	// ************************************************************
	wire [2:0] pin_code =
		(c_act) ? lpdct_pkg::PIN_ACT :
		(c_rd) ? lpdct_pkg::PIN_RD :
		(c_wr) ? lpdct_pkg::PIN_WR :
		(c_pre) ? lpdct_pkg::PIN_PRE :
		(c_ref || c_sre) ? lpdct_pkg::PIN_REF :
		(c_mrs || c_stat) ? lpdct_pkg::PIN_MRS : lpdct_pkg::PIN_NOP;
	wire [13:0] addr_ap = addr_i | 14'((c_rda || c_wra) << lpdct_pkg::AP_BIT);

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{ras_n_o, cas_n_o, we_n_o} <= lpdct_pkg::PIN_NOP;
			cs_n_o <= 1'b1;
			cke_o <= 1'b1;
			mem_clk_en_o <= 1'b1;
			ba_o <= 2'h0;
			addr_o <= 14'h0000;
		end else begin
			{ras_n_o, cas_n_o, we_n_o} <= issue ? pin_code : lpdct_pkg::PIN_NOP;
			cs_n_o <= !(issue && pin_code != lpdct_pkg::PIN_NOP);
			ba_o <= (issue && c_stat) ? lpdct_pkg::STAT_BA : bank_i;
			addr_o <= addr_ap;
			if (issue && (c_pde || c_sre)) begin
				cke_o <= 1'b0;
			end else if (issue && (c_pdx || c_srx)) begin
				cke_o <= 1'b1;
			end
			// Clock stops one cycle after the self-refresh entry goes out.
			mem_clk_en_o <= !(pstate == lpdct_pkg::PS_SREF) ||
				(issue && c_srx);
		end
	end

	// ************************************************************
	// Write data and strobes
	// ************************************************************
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ph <= 2'h0;
			wr_hold <= 32'h0000_0000;
			dq_o <= 32'h0000_0000;
		end else begin
			wr_ph <= iss_wr ? 2'h1 : (wr_ph == 2'h1 ? 2'h2 : 2'h0);
			if (iss_wr) begin
				wr_hold <= wr_data_i;
			end
			dq_o <= wr_hold;
		end
	end

	generate
		for (b = 0; b < 4; b++) begin : g_lane
			always_ff @(posedge ref_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					dqs_oe_o[b] <= 1'b0;
					dqs_o[b] <= 1'b0;
					dq_oe_o[b] <= 1'b0;
				end else begin
					// Strobe leaves high impedance with the command.
					dqs_oe_o[b] <= iss_wr || wr_ph == 2'h1;
					dqs_o[b] <= wr_ph == 2'h1;
					dq_oe_o[b] <= wr_ph == 2'h1;
				end
			end
		end
	endgenerate

	// ************************************************************
	// Read return
	// ************************************************************
	// The filter and the data register add two stages after the
	// synchroniser, so the valid pulse waits until the word stands.
	wire [2:0] tap = 3'(lat + 4'(lpdct_pkg::SYNC_LAT) + 4'h1);
	wire [31:0] dq_diff = dq_s2 ^ dq_s3;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dq_s1 <= 32'h0000_0000;
			dq_s2 <= 32'h0000_0000;
			dq_s3 <= 32'h0000_0000;
			dq_filt <= 32'h0000_0000;
			rd_pipe <= 8'h00;
			rd_valid_o <= 1'b0;
			rd_data_o <= 32'h0000_0000;
		end else begin
			dq_s1 <= dq_i;
			dq_s2 <= dq_s1;
			dq_s3 <= dq_s2;
			dq_filt <= (dq_s3 & ~dq_diff) | (dq_filt & dq_diff);
			rd_pipe <= {rd_pipe[6:0], iss_rd && !stat_pend};
			rd_valid_o <= rd_pipe[tap];
			rd_data_o <= dq_filt;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_quiet2;
		!issue [*2];
	endsequence
	sequence s_xsr_wait;
		(!issue && mem_clk_en_o) [*2];
	endsequence

	property p_rfc;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		issue && c_ref |=> s_quiet2;
	endproperty
	a_rfc: assert property (p_rfc) else $error("command inside tRFC");

	property p_stat_rd;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		issue && c_stat |=> !iss_rd;
	endproperty
	a_stat_rd: assert property (p_stat_rd)
		else $error("status read early");

	property p_src;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		iss_rd && stat_pend |=> s_quiet2 ##1 (!cl3_i || !issue);
	endproperty
	a_src: assert property (p_src)
		else $error("command inside tSRC");

	property p_wrr;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		iss_wr |=> !iss_rd;
	endproperty
	a_wrr: assert property (p_wrr) else $error("read after write early");

	property p_dal;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		issue && c_wra |=> rp_cnt[$past(bank_i)] == dal_cyc;
	endproperty
	a_dal: assert property (p_dal) else $error("wrong write precharge delay");

	property p_xsr;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		issue && c_srx |=> s_xsr_wait;
	endproperty
	a_xsr: assert property (p_xsr) else $error("self refresh exit early");

	property p_rda;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		issue && c_rda |-> ras_cnt[bank_i] <= 4'h1;
	endproperty
	a_rda: assert property (p_rda) else $error("auto precharge before tRAS");

	property p_rd_ret;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		iss_rd && !stat_pend && !cl3_i |-> ##8 rd_valid_o;
	endproperty
	a_rd_ret: assert property (p_rd_ret)
		else $error("read return late");

	property p_lane;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		dq_oe_o != 4'h0 |-> dqs_oe_o == dq_oe_o && $past(dqs_oe_o) == 4'hf;
	endproperty
	a_lane: assert property (p_lane) else $error("strobe lane mismatch");
endmodule : lpdct_ctrl

// File: tb/lpdct_mem_model.sv
module lpdct_mem_model (
	// Clock and configuration
	input wire logic ref_clk_i,
	input wire logic [1:0] grade_i,
	input wire logic cl3_i,
	// Memory pins
	input wire logic clk_en_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic [2:0] code_i,
	input wire logic [1:0] ba_i,
	input wire logic [13:0] addr_i,
	input wire logic [31:0] dq_i,
	input wire logic [3:0] dq_oe_i,
	input wire logic [3:0] dqs_oe_i,
	output logic [31:0] dq_o,
	// Count of spacing and strobe breaches seen
	output int viol_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Spacings in 40 ns cycles, each rounded up
	// ********
	localparam int RAS [4] = '{1, 2, 2, 2};
	localparam int WRR [4] = '{2, 2, 1, 1};
	localparam int XP [4] = '{2, 2, 1, 1};
	logic [31:0] mem [logic [10:0]];
	logic [31:0] rdata;
	logic [10:0] wkey;
	logic [1:0] b;
	int cyc = 0, t_ref = -9, t_mrs = -9, t_wr = -9, t_stat = -9, t_srd = -9;
	int t_act [4] = '{default: -9};
	int t_wra [4] = '{default: -9};
	int t_exit = 0, need = 0, runs = 0, rd_cnt = 0, hold = 0;
	bit in_sr = 0, cke_q = 1, wpend = 0, exit_pend = 0;

	initial begin
		viol_o = 0;
		dq_o = 32'h0000_0000;
	end

	task automatic chk(input bit ok);
		if (!ok) begin
			viol_o++;
		end
	endtask : chk

	always @(posedge ref_clk_i) begin
		cyc++;
		b = ba_i;
		if (hold > 0) begin
			hold--;
			// A released bus must not keep showing the last word.
			if (hold == 0) begin
				dq_o <= ~dq_o;
			end
		end
		if (rd_cnt > 0) begin
			rd_cnt--;
			if (rd_cnt == 1) begin
				dq_o <= rdata;
				hold = 3;
			end
		end
		if (wpend) begin
			chk(dq_oe_i === 4'hf && dqs_oe_i === 4'hf);
			mem[wkey] = dq_i;
			wpend = 0;
		end
		if (!cke_i && !clk_en_i) begin
			in_sr = 1;
		end
		if (clk_en_i) begin
			runs++;
		end
		if (cke_i && !cke_q) begin
			exit_pend = 1;
			t_exit = cyc;
			runs = 0;
			need = in_sr ? 3 : XP[grade_i];
		end
		cke_q = cke_i;
		if (cke_i && !cs_n_i && code_i != lpdct_pkg::PIN_NOP) begin
			if (exit_pend) begin
				chk(cyc - t_exit >= need);
				chk(!in_sr || runs >= 2);
				exit_pend = 0;
				in_sr = 0;
			end
			chk(cyc - t_ref >= 3);
			chk(cyc - t_mrs >= 2);
			chk(cyc - t_srd >= (cl3_i ? 4 : 3));
			case (code_i)
				lpdct_pkg::PIN_ACT: begin
					chk(cyc - t_act[b ^ 2'h1] >= 1);
					chk(cyc - t_wra[b] >= 3);
					t_act[b] = cyc;
				end
				lpdct_pkg::PIN_RD: begin
					chk(cyc - t_act[b] >= 1);
					chk(cyc - t_wr >= 1 + WRR[grade_i]);
					chk(!addr_i[10] || cyc - t_act[b] >= RAS[grade_i] - 1);
					if (t_stat > t_srd) begin
						t_srd = cyc;
					end else begin
						rdata = mem[{b, addr_i[8:0]}];
						rd_cnt = cl3_i ? 3 : 2;
					end
				end
				lpdct_pkg::PIN_WR: begin
					chk(cyc - t_act[b] >= 1);
					chk(dqs_oe_i === 4'hf);
					chk(!addr_i[10] || cyc - t_act[b] >= RAS[grade_i] - 1);
					wkey = {b, addr_i[8:0]};
					wpend = 1;
					t_wr = cyc;
					if (addr_i[10]) begin
						t_wra[b] = cyc;
					end
				end
				lpdct_pkg::PIN_PRE: begin
					chk(cyc - t_wr >= 2);
				end
				lpdct_pkg::PIN_REF: begin
					t_ref = cyc;
				end
				lpdct_pkg::PIN_MRS: begin
					t_mrs = cyc;
					if (b == lpdct_pkg::STAT_BA) begin
						t_stat = cyc;
					end
				end
				default: begin
				end
			endcase
		end
	end
endmodule : lpdct_mem_model

// File: tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Bench state and hookup
	// ********
	localparam int WRR [4] = '{2, 2, 1, 1};
	localparam int XP [4] = '{2, 2, 1, 1};
	logic ref_clk_i = 0, nrst_i = 0, cl3_i = 0, cmd_valid_i = 0;
	logic [1:0] grade_i = 2'h0, bank_i = 2'h0;
	lpdct_pkg::lpdct_cmd_e cmd_i = lpdct_pkg::CMD_NOP;
	logic [13:0] addr_i = 14'h0000;
	logic [31:0] wr_data_i = 32'h0000_0000;
	logic cmd_ready_o, rd_valid_o, refresh_due_o, freq_chg_ok_o;
	logic mem_clk_en_o, cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o;
	logic [1:0] ba_o;
	logic [13:0] addr_o;
	logic [31:0] rd_data_o, dq_o, dq_i;
	logic [3:0] dq_oe_o, dqs_o, dqs_oe_o;
	int viol, mismatches = 0, tests_run = 0, cyc = 0, t_take = 0, rd_seen = 0;

	lpdct_ctrl u_dut (.ref_clk_i, .nrst_i, .grade_i, .cl3_i, .cmd_valid_i,
		.cmd_i, .bank_i, .addr_i, .wr_data_i, .cmd_ready_o, .rd_valid_o,
		.rd_data_o, .refresh_due_o, .freq_chg_ok_o, .mem_clk_en_o, .cke_o,
		.cs_n_o, .ras_n_o, .cas_n_o, .we_n_o, .ba_o, .addr_o, .dq_o, .dq_oe_o,
		.dq_i, .dqs_o, .dqs_oe_o);

	lpdct_mem_model u_mem (.ref_clk_i, .grade_i, .cl3_i,
		.clk_en_i(mem_clk_en_o), .cke_i(cke_o), .cs_n_i(cs_n_o),
		.code_i({ras_n_o, cas_n_o, we_n_o}), .ba_i(ba_o), .addr_i(addr_o),
		.dq_i(dq_o), .dq_oe_i(dq_oe_o), .dqs_oe_i(dqs_oe_o), .dq_o(dq_i),
		.viol_o(viol));

	always #20 ref_clk_i = ~ref_clk_i;

	always @(negedge ref_clk_i) begin
		rd_seen += int'(rd_valid_o === 1'b1);
		if (dq_oe_o === 4'hf) begin
			check(32'(dqs_o), 32'hf);
		end
	end

	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			conclude();
		end
	end

	// ********
	// Shared tasks
	// ********
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	// Called at a falling edge; returns at the falling edge after the take
	// with the request still up, so an issue or idle must follow at once.
	task automatic issue(input lpdct_pkg::lpdct_cmd_e c, input logic [1:0] b,
		input logic [13:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cmd_valid_i = 1'b1;
		cmd_i = c;
		bank_i = b;
		addr_i = a;
		wr_data_i = d;
		#1;
		while (cmd_ready_o !== 1'b1 && n < 40) begin
			@(negedge ref_clk_i);
			#1;
			n++;
		end
		check(32'(n < 40), 32'h1);
		@(negedge ref_clk_i);
		t_take = cyc;
	endtask : issue

	task automatic idle();
		cmd_valid_i = 1'b0;
		cmd_i = lpdct_pkg::CMD_NOP;
	endtask : idle

	task automatic pass(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : pass

	task automatic probe(input lpdct_pkg::lpdct_cmd_e c);
		cmd_valid_i = 1'b1;
		cmd_i = c;
		#1;
		check(cmd_ready_o, 1'b0);
		@(negedge ref_clk_i);
		idle();
		@(negedge ref_clk_i);
	endtask : probe

	// ********
	// Scenarios
	// ********
	task automatic t_refresh();
		int n;
		n = 0;
		while (refresh_due_o !== 1'b1 && n < 300) begin
			@(negedge ref_clk_i);
			n++;
		end
		check(32'(n > 150 && n <= 195), 32'h1);
		probe(lpdct_pkg::CMD_ACT);
		issue(lpdct_pkg::CMD_REF, 2'h0, 14'h0000, 32'h0);
		idle();
		check(refresh_due_o, 1'b0);
		$display("test refresh done");
	endtask : t_refresh

	task automatic t_rw(input int i);
		int t0, lat;
		logic [1:0] b;
		logic [31:0] d;
		b = 2'(i);
		d = 32'h4433_2211 + 32'(i);
		lat = 0;
		grade_i = 2'(i >> 1);
		cl3_i = i[0];
		issue(lpdct_pkg::CMD_REF, 2'h0, 14'h0000, 32'h0);
		t0 = t_take;
		issue(lpdct_pkg::CMD_ACT, b, 14'h0123, 32'h0);
		check(32'(t_take - t0), 32'h3);
		t0 = t_take;
		issue(lpdct_pkg::CMD_WR, b, 14'h0040, d);
		check(32'(t_take - t0), 32'h1);
		t0 = t_take;
		issue(lpdct_pkg::CMD_RD, b, 14'h0040, 32'h0);
		check(32'(t_take - t0), 32'(1 + WRR[i >> 1]));
		idle();
		while (rd_valid_o !== 1'b1 && lat < 12) begin
			@(negedge ref_clk_i);
			lat++;
		end
		check(32'(lat), cl3_i ? 32'h8 : 32'h7);
		check(rd_data_o, d);
		issue(lpdct_pkg::CMD_PRE, b, 14'h0000, 32'h0);
		idle();
		pass(4);
		$display("test read-write %0d done", i);
	endtask : t_rw

	task automatic t_pre();
		int t0;
		grade_i = 2'h1;
		cl3_i = 1'b0;
		issue(lpdct_pkg::CMD_REF, 2'h0, 14'h0000, 32'h0);
		issue(lpdct_pkg::CMD_ACT, 2'h2, 14'h0007, 32'h0);
		t0 = t_take;
		issue(lpdct_pkg::CMD_ACT, 2'h3, 14'h0008, 32'h0);
		check(32'(t_take - t0), 32'h1);
		t0 = t_take;
		issue(lpdct_pkg::CMD_RDA, 2'h3, 14'h0010, 32'h0);
		check(32'(t_take - t0), 32'h1);
		issue(lpdct_pkg::CMD_WR, 2'h2, 14'h0011, 32'h0a0b_0c0d);
		t0 = t_take;
		issue(lpdct_pkg::CMD_PRE, 2'h2, 14'h0000, 32'h0);
		check(32'(t_take - t0), 32'h2);
		issue(lpdct_pkg::CMD_ACT, 2'h2, 14'h0009, 32'h0);
		issue(lpdct_pkg::CMD_WRA, 2'h2, 14'h0012, 32'h1122_3344);
		t0 = t_take;
		issue(lpdct_pkg::CMD_ACT, 2'h2, 14'h0009, 32'h0);
		check(32'(t_take - t0), 32'h3);
		issue(lpdct_pkg::CMD_PRE, 2'h2, 14'h0000, 32'h0);
		idle();
		pass(8);
		$display("test precharge done");
	endtask : t_pre

	task automatic t_stat();
		int t0, n;
		grade_i = 2'h0;
		cl3_i = 1'b1;
		n = rd_seen;
		issue(lpdct_pkg::CMD_REF, 2'h0, 14'h0000, 32'h0);
		issue(lpdct_pkg::CMD_STAT, 2'h0, 14'h0000, 32'h0);
		t0 = t_take;
		issue(lpdct_pkg::CMD_RD, 2'h0, 14'h0000, 32'h0);
		check(32'(t_take - t0), 32'h2);
		t0 = t_take;
		issue(lpdct_pkg::CMD_MRS, 2'h0, 14'h0032, 32'h0);
		check(32'(t_take - t0), 32'h4);
		t0 = t_take;
		issue(lpdct_pkg::CMD_MRS, 2'h0, 14'h0032, 32'h0);
		check(32'(t_take - t0), 32'h2);
		idle();
		pass(10);
		check(32'(rd_seen - n), 32'h0);
		$display("test status read done");
	endtask : t_stat

	task automatic t_pd(input logic [1:0] g);
		int t0;
		grade_i = g;
		issue(lpdct_pkg::CMD_REF, 2'h0, 14'h0000, 32'h0);
		check(freq_chg_ok_o, 1'b0);
		issue(lpdct_pkg::CMD_PDE, 2'h0, 14'h0000, 32'h0);
		idle();
		pass(2);
		check(cke_o, 1'b0);
		check(freq_chg_ok_o, 1'b1);
		probe(lpdct_pkg::CMD_ACT);
		issue(lpdct_pkg::CMD_PDX, 2'h0, 14'h0000, 32'h0);
		t0 = t_take;
		issue(lpdct_pkg::CMD_ACT, 2'h1, 14'h0005, 32'h0);
		check(32'(t_take - t0), 32'(XP[g]));
		issue(lpdct_pkg::CMD_PRE, 2'h1, 14'h0000, 32'h0);
		idle();
		pass(3);
		$display("test power-down %0d done", g);
	endtask : t_pd

	task automatic t_sr();
		int t0;
		grade_i = 2'h0;
		issue(lpdct_pkg::CMD_REF, 2'h0, 14'h0000, 32'h0);
		issue(lpdct_pkg::CMD_SRE, 2'h0, 14'h0000, 32'h0);
		idle();
		pass(4);
		check(mem_clk_en_o, 1'b0);
		check(freq_chg_ok_o, 1'b1);
		issue(lpdct_pkg::CMD_SRX, 2'h0, 14'h0000, 32'h0);
		t0 = t_take;
		issue(lpdct_pkg::CMD_ACT, 2'h0, 14'h0006, 32'h0);
		check(32'(t_take - t0), 32'h3);
		issue(lpdct_pkg::CMD_PRE, 2'h0, 14'h0000, 32'h0);
		idle();
		pass(3);
		$display("test self refresh done");
	endtask : t_sr

	initial begin
		repeat (5) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		nrst_i = 1'b1;
		t_refresh();
		for (int i = 0; i < 8; i++) begin
			t_rw(i);
		end
		t_pre();
		t_stat();
		t_pd(2'h0);
		t_pd(2'h2);
		t_sr();
		check(32'(viol), 32'h0);
		conclude();
	end
endmodule : tb_top
